// ==== bench/testbench.sv ====
// self-checking testbench for the conversion sequence control block
`timescale 1ns/1ps
module testbench;
    import asc_pkg::*;
    localparam logic [31:0] A_START = 32'h000002D0; // start control byte address
    localparam logic [31:0] A_SEQ = 32'h000002D4; // sequence control byte address
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic ext_trigger_pin = 1'b0;
    logic timer_compare_event = 1'b0;
    logic [3:0] ref_onehot;
    logic [9:0] dec_rate;
    logic [3:0] result_bits;
    logic [3:0] mux_code;
    logic [2:0] ain_pos;
    logic [2:0] ain_neg;
    logic diff_mode;
    logic fixed_source;
    logic conv_active;
    logic sample_ready;
    logic [DMA_TRIG_N-1:0] dma_trigger;
    logic dma_trigger_all;
    int mismatches = 0;
    int checked = 0;
    logic [31:0] rd;
    int gap;

    // one adc tick per clock keeps every conversion short
    asc_top #(.ADC_DIV(1)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_trigger_pin(ext_trigger_pin), .timer_compare_event(timer_compare_event),
        .ref_onehot(ref_onehot), .dec_rate(dec_rate), .result_bits(result_bits),
        .mux_code(mux_code), .ain_pos(ain_pos), .ain_neg(ain_neg), .diff_mode(diff_mode),
        .fixed_source(fixed_source), .conv_active(conv_active), .sample_ready(sample_ready),
        .dma_trigger(dma_trigger), .dma_trigger_all(dma_trigger_all)
    );

    // free running system clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    // compare one value; four-state so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    // single ahb-lite word transfer; the wait loops never assume zero wait states
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask : ahb

    // wait for the next sample pulse under a bound, then judge its dma line
    task automatic wait_sample(input logic [DMA_TRIG_N-1:0] exp_dma, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (sample_ready !== 1'b1 && n < 3000);
        chk(32'(dma_trigger), 32'(exp_dma), "dma trigger");
        chk(32'(dma_trigger_all), 32'h1, "all channels trigger");
    endtask : wait_sample

    // software start with start select kept at software
    task automatic sw_start();
        ahb(1'b1, A_START, 32'h70, rd);
        @(posedge clk_sys);
        #1;
    endtask : sw_start

    // reset values, then an unmapped write that must leave everything alone
    task automatic t_reset();
        chk(32'(ref_onehot), 32'h1, "reset reference");
        chk(32'(dec_rate), 32'd128, "reset rate");
        chk(32'(result_bits), 32'd9, "reset resolution");
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'h10, "sequence control reset");
        ahb(1'b0, A_START, 32'h0, rd);
        chk(rd, 32'h30, "start control reset");
        ahb(1'b1, 32'h000002DC, 32'hFF, rd);
        ahb(1'b0, 32'h000002DC, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'h10, "unmapped write ignored");
        $display("test reset done");
    endtask : t_reset

    // single-ended inputs 0..2, fastest rate, spacing between samples within 78 to 82 cycles
    task automatic t_single();
        ahb(1'b1, A_SEQ, 32'h02, rd);
        sw_start();
        chk(32'(conv_active), 32'h1, "started");
        chk(32'(mux_code), 32'h0, "first input");
        chk(32'(dec_rate), 32'd64, "rate 64");
        chk(32'(result_bits), 32'd7, "7 bits");
        wait_sample(9'h001, gap);
        wait_sample(9'h002, gap);
        chk(32'(gap >= 78 && gap <= 82), 32'h1, "conversion time");
        wait_sample(9'h004, gap);
        chk(32'(conv_active), 32'h0, "sequence ended");
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'h02, "last channel readback");
        $display("test single-ended done");
    endtask : t_single

    // differential pairs 0-1 and 2-3 with differential reference, rate 256
    task automatic t_diff();
        ahb(1'b1, A_SEQ, 32'hE9, rd);
        sw_start();
        chk(32'(ref_onehot), 32'h8, "differential reference");
        chk(32'(dec_rate), 32'd256, "rate 256");
        chk(32'(result_bits), 32'd10, "10 bits");
        chk(32'({diff_mode, mux_code, ain_pos, ain_neg}), 32'h601, "pair 0-1");
        wait_sample(9'h001, gap);
        chk(32'({diff_mode, mux_code, ain_pos, ain_neg}), 32'h653, "pair 2-3");
        wait_sample(9'h002, gap);
        chk(32'(conv_active), 32'h0, "pair sequence ended");
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'hE9, "pair readback");
        $display("test differential done");
    endtask : t_diff

    // one temperature conversion with supply reference, rate 512
    task automatic t_fixed();
        ahb(1'b1, A_SEQ, 32'hBE, rd);
        sw_start();
        chk(32'(ref_onehot), 32'h4, "supply reference");
        chk(32'(dec_rate), 32'd512, "rate 512");
        chk(32'(result_bits), 32'd12, "12 bits");
        chk(32'({fixed_source, mux_code}), 32'h1E, "temperature source");
        wait_sample(9'h100, gap);
        chk(32'(conv_active), 32'h0, "single conversion only");
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'hBE, "fixed readback");
        $display("test fixed source done");
    endtask : t_fixed

    // a write during a running sequence must wait for the next one
    task automatic t_latch();
        ahb(1'b1, A_SEQ, 32'h41, rd);
        sw_start();
        ahb(1'b1, A_SEQ, 32'hF0, rd);
        #1;
        chk(32'(ref_onehot), 32'h2, "input 7 reference held");
        chk(32'(dec_rate), 32'd64, "rate held");
        wait_sample(9'h001, gap);
        wait_sample(9'h002, gap);
        ahb(1'b0, A_SEQ, 32'h0, rd);
        chk(rd, 32'hF1, "written upper, converted lower");
        $display("test latch done");
    endtask : t_latch

    // pulse a start input for one cycle and check whether it started
    task automatic pulse(input logic on_pin, input logic exp_start);
        @(posedge clk_sys);
        ext_trigger_pin <= on_pin;
        timer_compare_event <= ~on_pin;
        @(posedge clk_sys);
        ext_trigger_pin <= 1'b0;
        timer_compare_event <= 1'b0;
        #1;
        chk(32'(conv_active), 32'(exp_start), "start event");
    endtask : pulse

    // pin, timer and full speed starts, and the wrong event ignored
    task automatic t_events();
        ahb(1'b1, A_SEQ, 32'h0C, rd);
        ahb(1'b1, A_START, 32'h00, rd);
        pulse(1'b0, 1'b0);
        pulse(1'b1, 1'b1);
        ahb(1'b0, A_START, 32'h0, rd);
        chk(rd, 32'h40, "busy readback");
        wait_sample(9'h100, gap);
        ahb(1'b1, A_START, 32'h20, rd);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        wait_sample(9'h100, gap);
        ahb(1'b1, A_START, 32'h10, rd);
        wait_sample(9'h100, gap);
        wait_sample(9'h100, gap);
        ahb(1'b1, A_START, 32'h30, rd);
        wait_sample(9'h100, gap);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(32'(conv_active), 32'h0, "full speed stopped");
        $display("test start events done");
    endtask : t_events

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // main sequence: reset for two cycles, then every scenario
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_diff();
        t_fixed();
        t_latch();
        t_events();
        print_verdict();
    end

    // watchdog: the scenarios need well under 5000 cycles
    initial begin
        #300000;
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : testbench

// ==== verilog/asc_pkg.sv ====
// constants, types and helpers for the conversion sequence control block
// What this block does
// - reference select lives in bits 7 to 6
// - reference codes: internal, input 7, supply, differential
// - decimation bits 5 to 4 apply to whole sequence
// - decimation 64/128/256/512 gives 7/9/10/12 bits
// - bits 3 to 0 name the sequence end
// - single-ended sequence runs input 0 up to end
// - differential sequence runs pair 0-1 up to end
// - pair codes map to inputs 0-1 through 6-7
// - codes 1100 up give one fixed-source conversion
// - channel field reads back last converted channel
// - start select picks pin, full, timer, software
// - each new sample raises its channel's dma trigger
package asc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] START_CTRL_INDEX = 8'hB4;
    localparam logic [7:0] SEQ_CTRL_INDEX = 8'hB5;
    localparam int ADDR_LSB = 2;
    localparam int INDEX_W = 8;
    // sequence control field positions
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int DEC_MSB = 5;
    localparam int DEC_LSB = 4;
    localparam int CH_MSB = 3;
    localparam int CH_LSB = 0;
    // start control field positions
    localparam int ST_BIT = 6;
    localparam int CONVERSION_START_SELECT_MSB = 5;
    localparam int CONVERSION_START_SELECT_LSB = 4;
    // reset values
    localparam logic [7:0] SEQ_CTRL_RESET = 8'h10;
    localparam logic [1:0] CONVERSION_START_SELECT_RESET = 2'h3;
    localparam logic [3:0] LAST_CH_RESET = 4'h0;
    // channel code landmarks
    localparam logic [3:0] CH_FIRST_SINGLE = 4'h0;
    localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
    localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
    localparam logic [3:0] CH_LAST_DIFF = 4'hB;
    localparam logic [3:0] CH_FIRST_FIXED = 4'hC;
    // timing in adc clock periods
    localparam logic [9:0] SETTLE_PERIODS = 10'h010;
    localparam int ADC_DIV_DEFAULT = 6;
    localparam int DMA_TRIG_N = 9;

    // reference choices
    typedef enum logic [1:0] {
        REF_INT_1V25 = 2'b00,
        REF_EXT_ANALOG_INPUT_7 = 2'b01,
        REF_SUPPLY = 2'b10,
        REF_EXT_DIFF = 2'b11
    } asc_ref_e;

    // start event choices
    typedef enum logic [1:0] {
        START_PIN = 2'b00,
        START_FULL = 2'b01,
        START_TIMER = 2'b10,
        START_SW = 2'b11
    } asc_start_e;

    // sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } asc_state_e;

    // decimation rate for a select code
    function automatic logic [9:0] asc_dec_rate(input logic [1:0] sel);
        case (sel)
            2'b00: asc_dec_rate = 10'h040;
            2'b01: asc_dec_rate = 10'h080;
            2'b10: asc_dec_rate = 10'h100;
            default: asc_dec_rate = 10'h200;
        endcase
    endfunction : asc_dec_rate

    // result resolution in bits for a select code
    function automatic logic [3:0] asc_resolution(input logic [1:0] sel);
        case (sel)
            2'b00: asc_resolution = 4'h7;
            2'b01: asc_resolution = 4'h9;
            2'b10: asc_resolution = 4'hA;
            default: asc_resolution = 4'hC;
        endcase
    endfunction : asc_resolution

    // conversion length: decimation plus mux settling
    function automatic logic [9:0] asc_conv_len(input logic [1:0] sel);
        asc_conv_len = asc_dec_rate(sel) + SETTLE_PERIODS;
    endfunction : asc_conv_len

    // first channel of a sequence ending at code end_ch
    function automatic logic [3:0] asc_first_ch(input logic [3:0] end_ch);
        if (end_ch >= CH_FIRST_FIXED) begin
            asc_first_ch = end_ch;
        end else if (end_ch >= CH_FIRST_DIFF) begin
            asc_first_ch = CH_FIRST_DIFF;
        end else begin
            asc_first_ch = CH_FIRST_SINGLE;
        end
    endfunction : asc_first_ch

    // dma trigger line for a channel code
    function automatic logic [DMA_TRIG_N-1:0] asc_dma_line(input logic [3:0] ch);
        logic [3:0] idx;
        idx = CH_FIRST_SINGLE;
        if (ch <= CH_LAST_SINGLE) begin
            idx = ch;
        end else if (ch <= CH_LAST_DIFF) begin
            idx = 4'(ch - CH_FIRST_DIFF);
        end else begin
            idx = 4'(DMA_TRIG_N - 1);
        end
        asc_dma_line = DMA_TRIG_N'(1) << idx;
    endfunction : asc_dma_line
endpackage : asc_pkg

// ==== verilog/asc_reg_if.sv ====
// carrier between the register slave and the sequencer core
`timescale 1ns/1ps
interface asc_reg_if;
    logic [7:0] seq_ctrl; // written sequence control value
    logic [1:0] start_sel; // start event select
    logic sw_start; // one-cycle software start
    logic busy; // sequence running
    logic [3:0] last_ch; // most recently converted channel
    modport regs (output seq_ctrl, output start_sel, output sw_start, input busy, input last_ch);
    modport core (input seq_ctrl, input start_sel, input sw_start, output busy, output last_ch);
endinterface : asc_reg_if

// ==== verilog/asc_regs.sv ====
// ahb-lite register slave for the sequence and start control registers
`timescale 1ns/1ps
module asc_regs
    import asc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    asc_reg_if.regs rif
);
    logic [7:0] seq_ctrl; // stored sequence control
    logic [1:0] start_sel; // stored start select
    logic wr_pend; // write in data phase
    logic [INDEX_W-1:0] wr_index; // index of pending write
    logic [31:0] next_hrdata;
    logic [7:0] next_seq_ctrl;
    logic [1:0] next_start_sel;
    logic next_wr_pend;
    logic [INDEX_W-1:0] next_wr_index;
    logic next_sw_start;
    logic sw_start;
    logic addr_ok; // address phase hits the mapped window
    logic take; // address phase taken this edge

    // index of a bus address, upper bits must be zero to map
    function automatic logic [INDEX_W-1:0] reg_index(input logic [31:0] a);
        reg_index = a[ADDR_LSB+INDEX_W-1:ADDR_LSB];
    endfunction : reg_index

    // zero wait state slave, never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[31:ADDR_LSB+INDEX_W] == '0) && (haddr[ADDR_LSB-1:0] == '0);

    // next state of registers and read data
    always_comb begin
        next_seq_ctrl = seq_ctrl;
        next_start_sel = start_sel;
        next_wr_pend = take && hwrite && addr_ok;
        next_wr_index = reg_index(haddr);
        next_hrdata = hrdata;
        next_sw_start = 1'b0;
        // data phase of a write
        if (wr_pend) begin
            if (wr_index == SEQ_CTRL_INDEX) begin
                next_seq_ctrl = hwdata[7:0];
            end else if (wr_index == START_CTRL_INDEX) begin
                next_start_sel = hwdata[CONVERSION_START_SELECT_MSB:CONVERSION_START_SELECT_LSB];
                if (hwdata[ST_BIT] && (hwdata[CONVERSION_START_SELECT_MSB:CONVERSION_START_SELECT_LSB] == START_SW) && !rif.busy) begin
                    next_sw_start = 1'b1;
                end
            end
        end
        // read data captured at the address phase, unmapped reads zero
        if (take && !hwrite) begin
            next_hrdata = '0;
            if (addr_ok && reg_index(haddr) == SEQ_CTRL_INDEX) begin
                // channel field shows last converted channel
                next_hrdata[7:0] = {seq_ctrl[REF_MSB:DEC_LSB], rif.last_ch};
            end else if (addr_ok && reg_index(haddr) == START_CTRL_INDEX) begin
                next_hrdata[ST_BIT] = rif.busy || sw_start;
                next_hrdata[CONVERSION_START_SELECT_MSB:CONVERSION_START_SELECT_LSB] = start_sel;
            end
        end
    end

    // register stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq_ctrl <= SEQ_CTRL_RESET;
            start_sel <= CONVERSION_START_SELECT_RESET;
            wr_pend <= 1'b0;
            wr_index <= '0;
            hrdata <= '0;
            sw_start <= 1'b0;
        end else begin
            seq_ctrl <= next_seq_ctrl;
            start_sel <= next_start_sel;
            wr_pend <= next_wr_pend;
            wr_index <= next_wr_index;
            hrdata <= next_hrdata;
            sw_start <= next_sw_start;
        end
    end

    assign rif.seq_ctrl = seq_ctrl;
    assign rif.start_sel = start_sel;
    assign rif.sw_start = sw_start;

    // read of the sequence register returns the converted channel
    // readback check
    a_ch_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && !hwrite && addr_ok && reg_index(haddr) == SEQ_CTRL_INDEX)
        |=> hrdata[3:0] == $past(rif.last_ch))
        else $error("channel readback mismatch");
endmodule : asc_regs

// ==== verilog/asc_top.sv ====
// conversion sequence control: start selection, sequencer, mux and dma trigger outputs
`timescale 1ns/1ps
module asc_top
    import asc_pkg::*;
#(
    parameter int ADC_DIV = ADC_DIV_DEFAULT // system clocks per adc clock
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ext_trigger_pin,
    input wire logic timer_compare_event,
    output logic [3:0] ref_onehot,
    output logic [9:0] dec_rate,
    output logic [3:0] result_bits,
    output logic [3:0] mux_code,
    output logic [2:0] ain_pos,
    output logic [2:0] ain_neg,
    output logic diff_mode,
    output logic fixed_source,
    output logic conv_active,
    output logic sample_ready,
    output logic [DMA_TRIG_N-1:0] dma_trigger,
    output logic dma_trigger_all
);
    localparam int DIV_W = (ADC_DIV > 1) ? $clog2(ADC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ADC_DIV - 1);

    // elaboration check: the divider cannot make a rate faster than the system clock
    if (ADC_DIV < 1) begin : g_div_check
        $error("ADC_DIV must be at least 1");
    end

    asc_reg_if rif ();

    // register slave on the bus
    asc_regs u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rif(rif.regs)
    );

    asc_state_e state; // sequencer state
    asc_state_e next_state;

    logic [1:0] lat_ref; // reference latched at start
    logic [1:0] next_lat_ref;

    logic [1:0] lat_dec; // decimation latched at start
    logic [1:0] next_lat_dec;

    logic [3:0] lat_end; // end channel latched at start
    logic [3:0] next_lat_end;

    logic [3:0] cur_ch; // channel being converted
    logic [3:0] next_cur_ch;

    logic [9:0] cnt; // adc periods left in this conversion
    logic [9:0] next_cnt;

    logic [DIV_W-1:0] div_cnt; // adc clock divider
    logic [DIV_W-1:0] next_div_cnt;

    logic [3:0] last_ch; // most recent finished channel
    logic [3:0] next_last_ch;

    logic next_sample_ready;
    logic [DMA_TRIG_N-1:0] next_dma_trigger;

    logic adc_tick; // one-cycle adc clock enable
    logic start_evt; // selected start event
    logic seq_done; // this conversion is the last one

    // adc clock enable divider
    always_comb begin
        adc_tick = (div_cnt == DIV_LAST);
        next_div_cnt = adc_tick ? '0 : DIV_W'(div_cnt + 1'b1);
    end

    always_comb begin
        case (asc_start_e'(rif.start_sel))
            START_PIN: start_evt = ext_trigger_pin;
            START_FULL: start_evt = 1'b1;
            START_TIMER: start_evt = timer_compare_event;
            START_SW: start_evt = rif.sw_start;
            default: start_evt = 1'b0;
        endcase
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        next_lat_ref = lat_ref;
        next_lat_dec = lat_dec;
        next_lat_end = lat_end;
        next_cur_ch = cur_ch;
        next_cnt = cnt;
        next_last_ch = last_ch;
        // pulses idle low
        next_sample_ready = 1'b0;
        next_dma_trigger = '0;
        // fixed sources stop after one; stop at end code
        seq_done = (cur_ch == lat_end) || (cur_ch >= CH_FIRST_FIXED);
        case (state)
            ST_IDLE: begin
                if (start_evt) begin
                    next_lat_ref = rif.seq_ctrl[REF_MSB:REF_LSB];
                    next_lat_dec = rif.seq_ctrl[DEC_MSB:DEC_LSB];
                    next_lat_end = rif.seq_ctrl[CH_MSB:CH_LSB];
                    // end code picks the first channel too
                    next_cur_ch = asc_first_ch(rif.seq_ctrl[CH_MSB:CH_LSB]);
                    next_cnt = asc_conv_len(rif.seq_ctrl[DEC_MSB:DEC_LSB]);
                    next_state = ST_CONV;
                end
            end
            // one period per adc tick
            ST_CONV: begin
                if (adc_tick) begin
                    if (cnt == 10'h001) begin
                        // sample ready raises its dma line
                        next_sample_ready = 1'b1;
                        next_dma_trigger = asc_dma_line(cur_ch);
                        next_last_ch = cur_ch;
                        if (seq_done) begin
                            next_state = ST_IDLE;
                        end else begin
                            // step to the next input or pair
                            next_cur_ch = 4'(cur_ch + 4'h1);
                            next_cnt = asc_conv_len(lat_dec);
                        end
                    end else begin
                        next_cnt = 10'(cnt - 10'h001);
                    end
                end
            end
            // stray code returns to idle
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            lat_ref <= SEQ_CTRL_RESET[REF_MSB:REF_LSB];
            lat_dec <= SEQ_CTRL_RESET[DEC_MSB:DEC_LSB];
            lat_end <= SEQ_CTRL_RESET[CH_MSB:CH_LSB];
            cur_ch <= CH_FIRST_SINGLE;
            cnt <= '0;
            div_cnt <= '0;
            last_ch <= LAST_CH_RESET;
            sample_ready <= 1'b0;
            dma_trigger <= '0;
        end else begin
            state <= next_state;
            lat_ref <= next_lat_ref;
            lat_dec <= next_lat_dec;
            lat_end <= next_lat_end;
            cur_ch <= next_cur_ch;
            cnt <= next_cnt;
            div_cnt <= next_div_cnt;
            last_ch <= next_last_ch;
            sample_ready <= next_sample_ready;
            dma_trigger <= next_dma_trigger;
        end
    end

    // analog front end controls, all decoded from latched flops
    always_comb begin
        ref_onehot = 4'h1 << lat_ref;
        // rate and resolution of the latched select
        dec_rate = asc_dec_rate(lat_dec);
        result_bits = asc_resolution(lat_dec);
        mux_code = cur_ch;
        diff_mode = (cur_ch >= CH_FIRST_DIFF) && (cur_ch <= CH_LAST_DIFF);
        fixed_source = (cur_ch >= CH_FIRST_FIXED);
        ain_pos = cur_ch[2:0];
        ain_neg = cur_ch[2:0];
        if (diff_mode) begin
            // pair code n gives inputs 2n and 2n+1
            ain_pos = {cur_ch[1:0], 1'b0};
            ain_neg = {cur_ch[1:0], 1'b1};
        end
    end

    // status outputs
    assign conv_active = (state == ST_CONV);
    assign dma_trigger_all = sample_ready;
    assign rif.busy = (state == ST_CONV);
    assign rif.last_ch = last_ch;

    // two consecutive cycles inside one running sequence
    sequence s_running;
        (state == ST_CONV) ##1 (state == ST_CONV);
    endsequence

    // an idle cycle with a start event
    sequence s_start;
        (state == ST_IDLE) && start_evt;
    endsequence

    a_cfg_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_running |-> $stable(lat_ref) && $stable(lat_dec)
            && $stable(lat_end))
        else $error("settings changed during a sequence");

    a_start_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_start |=> (state == ST_CONV)
            && (lat_end == $past(rif.seq_ctrl[CH_MSB:CH_LSB]))
            && (cnt == asc_conv_len($past(rif.seq_ctrl[DEC_MSB:DEC_LSB]))))
        else $error("start did not capture settings");

    a_first_channel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_start |=> cur_ch == (lat_end[3] ? (lat_end[2] ? lat_end : CH_FIRST_DIFF) : CH_FIRST_SINGLE))
        else $error("wrong first channel");

    a_sample_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_CONV && adc_tick && cnt == 10'h001)
        |=> sample_ready && (last_ch == $past(cur_ch)))
        else $error("sample not ready at end of count");

    a_seq_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sample_ready && state == ST_CONV)
        |-> (cur_ch == 4'(last_ch + 4'h1)) && (last_ch != lat_end))
        else $error("sequence did not step by one");

    a_single_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sample_ready && last_ch >= CH_FIRST_FIXED)
        |-> state == ST_IDLE)
        else $error("fixed source conversion did not stop");

    a_dma_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_ready |-> $onehot(dma_trigger)
            && (dma_trigger == asc_dma_line(last_ch)) && dma_trigger_all)
        else $error("dma trigger mismatch");

    a_dma_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_ready |=> !sample_ready && (dma_trigger == '0))
        else $error("dma trigger held too long");

    a_diff_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        diff_mode
        |-> (ain_pos == 3'(2 * (cur_ch - CH_FIRST_DIFF))) && (ain_neg == 3'(ain_pos + 3'h1)))
        else $error("differential pair mapping wrong");

    a_ref_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lat_ref == REF_EXT_DIFF)
        |-> ref_onehot == 4'h8)
        else $error("reference decode wrong");

    a_ref_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_start |=> $onehot(ref_onehot) && ref_onehot[$past(rif.seq_ctrl[REF_MSB:REF_LSB])])
        else $error("reference field not applied");

    a_diff_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_start ##0 (rif.seq_ctrl[CH_MSB] && !rif.seq_ctrl[CH_MSB-1])
        |=> diff_mode && (ain_pos == 3'h0) && (ain_neg == 3'h1))
        else $error("pair sequence start wrong");

    a_rate_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lat_dec == 2'b11)
        |-> (dec_rate == 10'h200) && (result_bits == 4'hC))
        else $error("decimation decode wrong");
endmodule : asc_top
